// ==== rtl/spw_top.v ====
// Smart panel write interface: registers, word queue and the engine
// that sends commands and pixel data to an external display module.
// Assumes one mclk domain; the DMA controller writes the queue port.
`timescale 1ns/1ps
`include "spw_defines.vh"

module spw_top #(
   parameter Q_DEPTH = 8,
   parameter Q_AW = 3,
   parameter HALF_CYC = `SPW_HALF_CYC
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Register port
   input wire [31:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // DMA handshake and queue back-pressure
   output wire dma_req,
   output wire queue_ready,
   // Panel pins
   output reg cmd_data_select_pin,
   output reg panel_select_pin,
   output reg panel_serial_clock_pin,
   output reg [17:0] panel_data_pins
);

   localparam ST_IDLE = 4'b0001;
   localparam ST_SETUP = 4'b0010;
   localparam ST_ACTIVE = 4'b0100;
   localparam ST_GAP = 4'b1000;

   ////////////////////////////////////////////////////////////////////////
   // Registers

   reg [15:0] config_r;
   reg auto_transfer_enable;
   reg [24:0] direct_r;
   reg [24:0] queue_last_r;
   reg [3:0] state_r;
   reg [3:0] state_nxt;

   wire transfer_type_sel = config_r[`SPW_F_TYPE];
   wire clock_edge_select = config_r[`SPW_F_CLKEDGE];
   wire cmd_data_polarity = config_r[`SPW_F_RSPOL];
   wire select_level_polarity = config_r[`SPW_F_CSPOL];
   wire [1:0] command_width_sel = config_r[`SPW_F_CW_HI:`SPW_F_CW_LO];
   wire [2:0] data_width_sel = config_r[`SPW_F_DW_HI:`SPW_F_DW_LO];
   wire [1:0] trig_sel = config_r[`SPW_F_TRIG_HI:`SPW_F_TRIG_LO];

   wire wr_cfg = reg_wr && (reg_addr == `SPW_ADDR_CONFIG);
   wire wr_ctl = reg_wr && (reg_addr == `SPW_ADDR_CONTROL);
   wire wr_dir = reg_wr && (reg_addr == `SPW_ADDR_DIRECT);
   wire wr_que = reg_wr && (reg_addr == `SPW_ADDR_QUEUE);
   // Flag and payload only; bits 30:24 are dropped
   wire [24:0] wr_word = {reg_wdata[`SPW_F_FLAG],
                          reg_wdata[`SPW_PAYLOAD_HI:0]};

   wire busy;
   wire [Q_AW:0] q_count;
   wire q_in_ready;
   wire q_out_valid;
   wire [24:0] q_out_data;
   reg q_pop;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         config_r <= `SPW_CONFIG_RST;
         auto_transfer_enable <= `SPW_CONTROL_RST;
         direct_r <= `SPW_DATA_RST;
         queue_last_r <= `SPW_DATA_RST;
      end else begin
         if (wr_cfg) begin
            config_r <= reg_wdata[15:0] & `SPW_CONFIG_MASK;
         end
         if (wr_ctl) begin
            auto_transfer_enable <= reg_wdata[0];
         end
         if (wr_dir) begin
            direct_r <= wr_word;
         end
         if (wr_que && q_in_ready) begin
            queue_last_r <= wr_word;
         end
      end
   end

   // Read data only in the cycle after the read strobe
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == `SPW_ADDR_CONFIG) begin
         reg_rdata <= {16'h0000, config_r};
      end else if (reg_addr == `SPW_ADDR_CONTROL) begin
         reg_rdata <= {31'h0000_0000, auto_transfer_enable};
      end else if (reg_addr == `SPW_ADDR_STATUS) begin
         reg_rdata <= {31'h0000_0000, busy};
      end else if (reg_addr == `SPW_ADDR_DIRECT) begin
         reg_rdata <= {direct_r[24], 7'h00, direct_r[23:0]};
      end else if (reg_addr == `SPW_ADDR_QUEUE) begin
         reg_rdata <= {queue_last_r[24], 7'h00, queue_last_r[23:0]};
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Word queue; direct and queue ports share it to keep word order

   spw_queue #(
      .W(25),
      .DEPTH(Q_DEPTH),
      .AW(Q_AW)
   ) u_queue (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(wr_dir || wr_que),
      .in_ready(q_in_ready),
      .in_data(wr_word),
      .out_valid(q_out_valid),
      .out_ready(q_pop),
      .out_data(q_out_data),
      .count(q_count)
   );

   assign queue_ready = q_in_ready;

   wire [Q_AW:0] q_room = Q_DEPTH[Q_AW:0] - q_count;
   reg trig_ok;

   always @* begin
      trig_ok = 1'b0;
      if (trig_sel == `SPW_TRIG_4) begin
         trig_ok = (q_room >= `SPW_TRIG_4_WORDS);
      end else if (trig_sel == `SPW_TRIG_8) begin
         trig_ok = (q_room >= `SPW_TRIG_8_WORDS);
      end
   end

   // Enable only gates the DMA request; register feeding is unaffected
   assign dma_req = auto_transfer_enable && trig_ok;

   ////////////////////////////////////////////////////////////////////////
   // Word decode at load

   reg [4:0] ld_width;
   reg [1:0] ld_beats;

   always @* begin
      ld_width = 5'd0;
      ld_beats = 2'd0;
      if (q_out_data[24]) begin
         // Flag set marks a command word
         case (command_width_sel)
            `SPW_CW_16: begin
               ld_width = 5'd16;
               ld_beats = 2'd1;
            end
            `SPW_CW_8: begin
               ld_width = 5'd8;
               ld_beats = 2'd1;
            end
            `SPW_CW_18: begin
               ld_width = 5'd18;
               ld_beats = 2'd1;
            end
            default: begin
               ld_beats = 2'd0;
            end
         endcase
      end else begin
         case (data_width_sel)
            `SPW_DW_18X1: begin
               ld_width = 5'd18;
               ld_beats = 2'd1;
            end
            `SPW_DW_16X1: begin
               ld_width = 5'd16;
               ld_beats = 2'd1;
            end
            `SPW_DW_8X3: begin
               ld_width = 5'd8;
               ld_beats = 2'd3;
            end
            `SPW_DW_8X2: begin
               ld_width = 5'd8;
               ld_beats = 2'd2;
            end
            `SPW_DW_8X1: begin
               ld_width = 5'd8;
               ld_beats = 2'd1;
            end
            `SPW_DW_9X2: begin
               ld_width = 5'd9;
               ld_beats = 2'd2;
            end
            default: begin
               ld_beats = 2'd0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer engine

   reg [24:0] word_r;
   reg [4:0] width_r;
   reg [1:0] left_r;
   reg [4:0] bit_r;
   reg [7:0] cnt_r;
   reg serial_r;

   wire [6:0] shamt = {2'b00, width_r} * {5'b00000, left_r - 2'd1};
   wire [23:0] shifted = word_r[23:0] >> shamt;
   wire [17:0] beat_mask = 18'h3_ffff >> (5'd18 - width_r);
   wire [17:0] beat_val = shifted[17:0] & beat_mask;
   wire [4:0] bit_pos = width_r - 5'd1 - bit_r;
   wire [17:0] bit_sh = beat_val >> bit_pos;
   wire half_done = (cnt_r == HALF_CYC[7:0] - 8'd1);
   wire last_bit = !serial_r || (bit_r == width_r - 5'd1);

   always @* begin
      state_nxt = state_r;
      q_pop = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (q_out_valid) begin
               q_pop = 1'b1;
               // Reserved width codes drop the word
               if (ld_beats != 2'd0) begin
                  state_nxt = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            if (half_done) begin
               state_nxt = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (half_done) begin
               if (last_bit && left_r == 2'd1) begin
                  state_nxt = ST_GAP;
               end else begin
                  state_nxt = ST_SETUP;
               end
            end
         end
         ST_GAP: begin
            if (half_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         word_r <= `SPW_DATA_RST;
         width_r <= 5'd0;
         left_r <= 2'd0;
         bit_r <= 5'd0;
         cnt_r <= 8'd0;
         serial_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r != state_nxt) begin
            cnt_r <= 8'd0;
         end else if (state_r != ST_IDLE) begin
            cnt_r <= cnt_r + 8'd1;
         end
         if (state_r == ST_IDLE && q_out_valid) begin
            word_r <= q_out_data;
            width_r <= ld_width;
            left_r <= ld_beats;
            bit_r <= 5'd0;
            serial_r <= transfer_type_sel;
         end else if (state_r == ST_ACTIVE && half_done) begin
            if (last_bit) begin
               bit_r <= 5'd0;
               left_r <= left_r - 2'd1;
            end else begin
               bit_r <= bit_r + 5'd1;
            end
         end
      end
   end

   assign busy = (state_r != ST_IDLE) || q_out_valid;

   ////////////////////////////////////////////////////////////////////////
   // Pin drive, all from flip-flops

   wire is_cmd = word_r[24];
   wire sel_on = (state_r == ST_ACTIVE) ||
                 (serial_r && state_r == ST_SETUP);
   wire clk_idle = !clock_edge_select;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_data_select_pin <= 1'b1;
         panel_select_pin <= 1'b1;
         panel_serial_clock_pin <= 1'b1;
         panel_data_pins <= 18'h0_0000;
      end else begin
         // Command drives low unless polarity inverted
         cmd_data_select_pin <= !is_cmd ^ cmd_data_polarity;
         // Parallel: trailing edge of select samples the data
         panel_select_pin <= sel_on ^ !select_level_polarity;
         // Idle opposite the sampling edge, toggles only in serial
         panel_serial_clock_pin <= clk_idle ^
            (serial_r && state_r == ST_ACTIVE);
         if (serial_r) begin
            panel_data_pins <= 18'h0_0000;
            panel_data_pins[`SPW_SERIAL_LINE] <= bit_sh[0];
         end else if (panel_select_pin != select_level_polarity) begin
            // Held while select is active so the closing edge sees it
            panel_data_pins <= beat_val;
         end
      end
   end

endmodule

// ==== include/spw_defines.vh ====
// Constants for the smart panel write interface: register addresses,
// field positions, reset values, codes and timing counts.
// Assumes a 32-bit byte address on the plain register port.
`ifndef SPW_DEFINES_VH
`define SPW_DEFINES_VH

// Register byte addresses
`define SPW_ADDR_CONFIG 32'h1305_00a0
`define SPW_ADDR_CONTROL 32'h1305_00a4
`define SPW_ADDR_STATUS 32'h1305_00a8
`define SPW_ADDR_DIRECT 32'h1305_00ac
`define SPW_ADDR_QUEUE 32'h1305_00b0

// Reset values
`define SPW_CONFIG_RST 16'h0000
`define SPW_CONTROL_RST 1'b0
`define SPW_DATA_RST 25'h000_0000

// Writable bits of interface_config; all others read zero
`define SPW_CONFIG_MASK 16'hdf9b

// interface_config fields
`define SPW_F_TYPE 0
`define SPW_F_CLKEDGE 1
`define SPW_F_RSPOL 3
`define SPW_F_CSPOL 4
`define SPW_F_CW_LO 7
`define SPW_F_CW_HI 8
`define SPW_F_DW_LO 10
`define SPW_F_DW_HI 12
`define SPW_F_TRIG_LO 14
`define SPW_F_TRIG_HI 15

// Word layout in the data ports
`define SPW_F_FLAG 31
`define SPW_PAYLOAD_HI 23

// Data width codes
`define SPW_DW_18X1 3'b000
`define SPW_DW_16X1 3'b001
`define SPW_DW_8X3 3'b010
`define SPW_DW_8X2 3'b011
`define SPW_DW_8X1 3'b100
`define SPW_DW_9X2 3'b111

// Command width codes
`define SPW_CW_16 2'b00
`define SPW_CW_8 2'b01
`define SPW_CW_18 2'b10

// DMA threshold codes and room in words
`define SPW_TRIG_4 2'b00
`define SPW_TRIG_8 2'b01
`define SPW_TRIG_4_WORDS 4'd4
`define SPW_TRIG_8_WORDS 4'd8

// Serial data line inside the panel data bus
`define SPW_SERIAL_LINE 15

// Half period of serial clock and parallel strobe, in ns and cycles
`define SPW_MCLK_NS 40
`define SPW_HALF_NS 80
`define SPW_HALF_CYC ((`SPW_HALF_NS + `SPW_MCLK_NS - 1) / `SPW_MCLK_NS)

`endif

// ==== rtl/spw_queue.v ====
// Word queue between the register port and the panel shifter.
// Assumes both sides run on mclk; DEPTH must be a power of two.
`timescale 1ns/1ps

module spw_queue #(
   parameter W = 25,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Filling side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // Draining side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data,
   // Fill level
   output wire [AW:0] count
);

   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   wire push;
   wire pop;

   assign in_ready = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem[rp_r];
   assign count = cnt_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge mclk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

endmodule

// ==== verif/spw_top_props.sv ====
// Port checker of the smart panel write interface, bound to spw_top.
// Assumes one mclk domain and settings written through the port.
`timescale 1ns/1ps
`include "spw_defines.vh"

module spw_top_props (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Register port
   input wire [31:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // Flow control
   input wire dma_req,
   input wire queue_ready,
   // Panel pins
   input wire cmd_data_select_pin,
   input wire panel_select_pin,
   input wire panel_serial_clock_pin,
   input wire [17:0] panel_data_pins
);
   // Shadow of settings, seen only from the port
   reg [15:0] cfg_r;
   reg en_r;
   reg rd_full_r;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= 16'h0000;
         en_r <= 1'b0;
         rd_full_r <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `SPW_ADDR_CONFIG)
            cfg_r <= reg_wdata[15:0];
         if (reg_wr && reg_addr == `SPW_ADDR_CONTROL)
            en_r <= reg_wdata[0];
         rd_full_r <= reg_rd && reg_addr == `SPW_ADDR_STATUS && !queue_ready;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_cfg_rsv; $past(reg_rd) && $past(reg_addr) == `SPW_ADDR_CONFIG
      |-> (reg_rdata & 32'hffff_2064) == 32'h0000_0000; endproperty
   a_cfg_rsv: assert property (p_cfg_rsv) else $error("config spare bit");
   property p_ctl_rsv; $past(reg_rd) && $past(reg_addr) == `SPW_ADDR_CONTROL
      |-> reg_rdata[31:1] == 31'h0000_0000; endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control spare bit");
   property p_sts_rsv; $past(reg_rd) && $past(reg_addr) == `SPW_ADDR_STATUS
      |-> reg_rdata[31:1] == 31'h0000_0000; endproperty
   a_sts_rsv: assert property (p_sts_rsv) else $error("status spare bit");
   property p_busy_full; rd_full_r |-> reg_rdata[0]; endproperty
   a_busy_full: assert property (p_busy_full) else $error("idle when full");
   property p_dma_off; !en_r |-> !dma_req; endproperty
   a_dma_off: assert property (p_dma_off) else $error("request when off");
   property p_trig_rsv; cfg_r[15] |-> !dma_req; endproperty
   a_trig_rsv: assert property (p_trig_rsv) else $error("reserved trigger");
   property p_full_dma; !queue_ready |-> !dma_req; endproperty
   a_full_dma: assert property (p_full_dma) else $error("request when full");
   property p_clk_par; !cfg_r[0] && $stable(cfg_r)
      |-> panel_serial_clock_pin == !cfg_r[1]; endproperty
   a_clk_par: assert property (p_clk_par) else $error("clock moved");
   property p_ser_line; cfg_r[0] && $stable(cfg_r) |-> panel_data_pins[14:0]
      == 15'h0000 && panel_data_pins[17:16] == 2'b00; endproperty
   a_ser_line: assert property (p_ser_line) else $error("serial spare line");
endmodule

bind spw_top spw_top_props u_props (.mclk(mclk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req),
   .queue_ready(queue_ready), .cmd_data_select_pin(cmd_data_select_pin),
   .panel_select_pin(panel_select_pin),
   .panel_serial_clock_pin(panel_serial_clock_pin),
   .panel_data_pins(panel_data_pins));

// ==== verif/spw_panel_model.sv ====
// Display module model: logs each beat as {command/data select level, data}.
// Assumes pins change on mclk; strap inputs set by the bench.
`timescale 1ns/1ps

module spw_panel_model (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Panel pins
   input wire cmd_data_select_pin,
   input wire panel_select_pin,
   input wire panel_serial_clock_pin,
   input wire [17:0] panel_data_pins,
   // Straps: serial mode, select level, active clock level
   input wire serial,
   input wire sel_level,
   input wire edge_level
);
   reg [18:0] log_r [0:63];
   reg [6:0] n_r;
   reg act_q;
   reg clk_q;
   reg [17:0] sh_r;
   wire act = (panel_select_pin == sel_level);
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         n_r <= 7'h00;
         act_q <= 1'b0;
         // Idle level of the clock pin, so no false edge after reset
         clk_q <= 1'b1;
         sh_r <= 18'h0_0000;
      end else begin
         act_q <= act;
         clk_q <= panel_serial_clock_pin;
         if (act && !act_q)
            sh_r <= 18'h0_0000;
         else if (serial && act && panel_serial_clock_pin == edge_level &&
                  clk_q != edge_level)
            sh_r <= {sh_r[16:0], panel_data_pins[15]};
         // Sampled on the closing edge of select
         if (act_q && !act) begin
            log_r[n_r[5:0]] <= {cmd_data_select_pin,
                                serial ? sh_r : panel_data_pins};
            n_r <= n_r + 7'h01;
         end
      end
   end
endmodule

// ==== verif/test_spw_top.sv ====
// Bench of the smart panel write interface: registers, every width
// code, serial words, queue back-pressure and the DMA request.
// Assumes spw_panel_model and the bound checker are compiled.
`timescale 1ns/1ps
`include "spw_defines.vh"

module test_spw_top;
   reg mclk = 1'b0;
   reg rst_n = 1'b0;
   reg [31:0] reg_addr = 32'h0000_0000;
   reg [31:0] reg_wdata = 32'h0000_0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg m_ser = 1'b0;
   reg m_sel = 1'b0;
   reg m_edge = 1'b0;
   wire [31:0] reg_rdata;
   wire dma_req;
   wire queue_ready;
   wire cmd_data_select_pin;
   wire panel_select_pin;
   wire panel_serial_clock_pin;
   wire [17:0] panel_data_pins;
   reg [31:0] rv;
   reg [31:0] last;
   reg [6:0] n0;
   reg qr_seen;
   integer bad_count = 0;
   integer total_checks = 0;
   integer i;
   integer acc;
   always #20 mclk = ~mclk;
   spw_top u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .dma_req(dma_req), .queue_ready(queue_ready),
      .cmd_data_select_pin(cmd_data_select_pin),
      .panel_select_pin(panel_select_pin),
      .panel_serial_clock_pin(panel_serial_clock_pin),
      .panel_data_pins(panel_data_pins));
   spw_panel_model u_panel (.mclk(mclk), .rst_n(rst_n),
      .cmd_data_select_pin(cmd_data_select_pin),
      .panel_select_pin(panel_select_pin),
      .panel_serial_clock_pin(panel_serial_clock_pin),
      .panel_data_pins(panel_data_pins), .serial(m_ser),
      .sel_level(m_sel), .edge_level(m_edge));
   ////////////////////////////////////////////////////////////
   function [3:0] kind(input [15:0] c, input [31:0] w);
      kind = w[31] ? {2'b10, c[8:7]} : {1'b0, c[12:10]};
   endfunction
   function integer nb(input [15:0] c, input [31:0] w);
      reg [3:0] k;
      begin
         k = kind(c, w);
         nb = (k == 2) ? 3 : (k == 3 || k == 7) ? 2 :
              (k == 0 || k == 1 || k == 4 || k == 8 || k == 9 ||
               k == 10) ? 1 : 0;
      end
   endfunction
   function [17:0] beat(input [15:0] c, input [31:0] w, input integer j);
      case (kind(c, w))
         4'h0, 4'ha: beat = w[17:0];
         4'h1, 4'h8: beat = 18'(w[15:0]);
         4'h2: beat = 18'(j == 0 ? w[23:16] : j == 1 ? w[15:8] : w[7:0]);
         4'h3: beat = 18'(j == 0 ? w[15:8] : w[7:0]);
         4'h7: beat = 18'(j == 0 ? w[17:9] : w[8:0]);
         default: beat = 18'(w[7:0]);
      endcase
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count = bad_count + 1;
         end
      end
   endtask
   task wr(input [31:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(negedge mclk);
         qr_seen = queue_ready;
         @(posedge mclk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [31:0] a);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1;
         rv = reg_rdata;
      end
   endtask
   task wait_idle;
      integer k;
      begin
         rv = 32'h0000_0001;
         for (k = 0; k < 300 && rv[0] !== 1'b0; k = k + 1)
            rd(`SPW_ADDR_STATUS);
         chk(rv, 32'h0000_0000);
      end
   endtask
   // One word through the queue, beats compared with the model log
   task run(input [15:0] c, input [31:0] w);
      integer j;
      begin
         m_ser = c[0];
         m_sel = c[4];
         m_edge = c[1];
         wr(`SPW_ADDR_CONFIG, {16'h0000, c});
         // A select level change may log one stray closing edge first
         repeat (3) @(negedge mclk);
         n0 = u_panel.n_r;
         wr(`SPW_ADDR_QUEUE, w);
         wait_idle;
         chk(32'(7'(u_panel.n_r - n0)), 32'(nb(c, w)));
         for (j = 0; j < nb(c, w); j = j + 1)
            chk(32'(u_panel.log_r[6'(n0 + j)]),
                32'({w[31] ~^ c[3], beat(c, w, j)}));
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      #400_000;
      bad_count = bad_count + 1;
      stop_test;
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(32'({cmd_data_select_pin, panel_select_pin,
               panel_serial_clock_pin, panel_data_pins}),
          32'h001c_0000);
      for (i = 0; i < 6; i = i + 1) begin
         rd(`SPW_ADDR_CONFIG + 4 * i);
         chk(rv, 32'h0000_0000);
      end
      wr(`SPW_ADDR_CONFIG, 32'hffff_ffff);
      rd(`SPW_ADDR_CONFIG);
      chk(rv, 32'h0000_df9b);
      wr(`SPW_ADDR_CONTROL, 32'hffff_ffff);
      rd(`SPW_ADDR_CONTROL);
      chk(rv, 32'h0000_0001);
      wr(`SPW_ADDR_CONTROL, 32'h0000_0000);
      wr(`SPW_ADDR_STATUS, 32'hffff_ffff);
      rd(`SPW_ADDR_STATUS);
      chk(rv, 32'h0000_0000);
      wr(`SPW_ADDR_CONFIG + 32'h14, 32'hffff_ffff);
      rd(`SPW_ADDR_CONFIG + 32'h14);
      chk(rv, 32'h0000_0000);
      wr(`SPW_ADDR_CONFIG, 32'h0000_1000);
      wr(`SPW_ADDR_DIRECT, 32'hffff_ff55);
      rd(`SPW_ADDR_DIRECT);
      chk(rv, 32'h80ff_ff55);
      wait_idle;
      run(16'h0800, 32'h00a5_5ac3);
      run(16'h0c18, 32'h0012_3456);
      run(16'h1000, 32'h0000_00e7);
      run(16'h1c00, 32'h0003_fe01);
      run(16'h0000, 32'h0002_aaaa);
      run(16'h0400, 32'h0000_beef);
      run(16'h0400, 32'h8000_1234);
      run(16'h1088, 32'h8000_00a9);
      run(16'h0110, 32'h8003_0f0f);
      run(16'h1400, 32'h0000_0011);
      run(16'h1800, 32'h0000_0022);
      run(16'h0180, 32'h8000_0033);
      run(16'h1003, 32'h0000_00c5);
      run(16'h1009, 32'h0000_003a);
      run(16'h1081, 32'h8000_0096);
      m_ser = 1'b0;
      m_sel = 1'b0;
      wr(`SPW_ADDR_CONFIG, 32'h0000_1000);
      wr(`SPW_ADDR_CONTROL, 32'h0000_0001);
      chk(32'(dma_req), 32'h0000_0001);
      wr(`SPW_ADDR_CONFIG, 32'h0000_5000);
      chk(32'(dma_req), 32'h0000_0001);
      n0 = u_panel.n_r;
      acc = 0;
      last = 32'h0000_0000;
      // Writes outpace the panel, so the queue must refuse some
      for (i = 0; i < 16; i = i + 1) begin
         wr(`SPW_ADDR_QUEUE, 32'h0000_0040 + i);
         if (qr_seen === 1'b1) begin
            acc = acc + 1;
            last = 32'h0000_0040 + i;
         end
      end
      chk(32'(acc < 16), 32'h0000_0001);
      rd(`SPW_ADDR_QUEUE);
      chk(rv, last);
      wait_idle;
      wr(`SPW_ADDR_CONTROL, 32'h0000_0000);
      chk(32'(7'(u_panel.n_r - n0)), 32'(acc));
      chk(32'(u_panel.log_r[6'(n0 + acc - 1)]),
          32'({1'b1, 10'h000, last[7:0]}));
      wr(`SPW_ADDR_CONFIG, 32'h0000_9000);
      wr(`SPW_ADDR_CONTROL, 32'h0000_0001);
      chk(32'(dma_req), 32'h0000_0000);
      wr(`SPW_ADDR_CONTROL, 32'h0000_0000);
      stop_test;
   end
endmodule
